/* design/fdtm_pkg.sv */
// Purpose: Shared constants and types for the dual fan tachometer monitor
// Assumes: Microcontroller byte registers at fixed addresses
// Notes:   Every offset and field lives here, with the register and counter reset values

package fdtm_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NUM_CH            = 2;
  localparam int PRESCALE_FIELD_W  = 2;
  localparam int PRESCALE_REG_W    = 4;
  localparam int CH_ONE            = 0;
  localparam int CH_TWO            = 1;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [15:0] ADDR_LATCH_ONE   = 16'h7F9B;
  localparam logic [15:0] ADDR_LATCH_TWO   = 16'h7F9C;
  localparam logic [15:0] ADDR_PRELOAD_ONE = 16'h7F9D;
  localparam logic [15:0] ADDR_PRELOAD_TWO = 16'h7F9E;
  localparam logic [15:0] ADDR_PRESCALER   = 16'h7F9F;

  // ************************************************************
  // Reset and fixed values
  // ************************************************************
  localparam logic [7:0] LATCH_RESET    = 8'h00;
  localparam logic [7:0] PRELOAD_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hFF;
  localparam logic [7:0] COUNT_THRESH   = 8'hC0;
  localparam logic [7:0] READ_IDLE      = 8'h00;
  localparam logic [3:0] PRESCALE_RESET = 4'h5;
  localparam logic [3:0] RESERVED_READ  = 4'h0;
  localparam logic [2:0] DIV_ZERO       = 3'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    DIV_BY_1 = 2'h0,
    DIV_BY_2 = 2'h1,
    DIV_BY_4 = 2'h2,
    DIV_BY_8 = 2'h3
  } fdtm_div_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } fdtm_bus_req_t;

  // Last divider count before a prescaled tick
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    logic [2:0] lim;
    lim = 3'h0;
    unique case (sel)
      DIV_BY_1: lim = 3'h0;
      DIV_BY_2: lim = 3'h1;
      DIV_BY_4: lim = 3'h3;
      DIV_BY_8: lim = 3'h7;
    endcase
    return lim;
  endfunction : div_limit

endpackage : fdtm_pkg

/* design/fdtm_sync_edge.sv */
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: asyncIn is slower than half of sys_clk
// Notes:   rise is one cycle, registered

`timescale 1ns/100ps

module fdtm_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      rise
);

  logic syncMeta;
  logic syncStable;
  logic syncPrev;

  // ************************************************************
  // Synchroniser
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncMeta   <= 1'b0;
      syncStable <= 1'b0;
      syncPrev   <= 1'b0;
    end else begin
      syncMeta   <= asyncIn;
      syncStable <= syncMeta;
      syncPrev   <= syncStable;
    end
  end

  // ************************************************************
  // Edge detect
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rise <= 1'b0;
    end else begin
      rise <= syncStable & ~syncPrev; // see (R15)
    end
  end

  edgePulse_a: assert property (@(posedge sys_clk) disable iff (rst) // see (R15)
    (syncStable && !syncPrev) |=> rise ##1 !rise)
    else $error("edge pulse missing or too long");

endmodule : fdtm_sync_edge

/* design/fdtm_prescaler.sv */
// Purpose: Per-channel timebase divider by 1, 2, 4 or 8
// Assumes: tick is a one-cycle pulse per timebase period
// Notes:   restart clears the divider phase

`timescale 1ns/100ps

module fdtm_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic [1:0] sel,
  output logic            divTick
);

  logic [2:0] divCount;
  logic       atLimit;

  assign atLimit = (divCount >= fdtm_pkg::div_limit(sel));
  assign divTick = tick & atLimit & ~restart; // see (R2)

  // ************************************************************
  // Divider
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCount <= fdtm_pkg::DIV_ZERO;
    end else if (restart) begin
      divCount <= fdtm_pkg::DIV_ZERO;
    end else if (tick) begin
      if (atLimit) begin
        divCount <= fdtm_pkg::DIV_ZERO; // see (R2)
      end else begin
        divCount <= 3'(divCount + 3'h1);
      end
    end
  end

  divByOne_a: assert property (@(posedge sys_clk) disable iff (rst) // see (R2)
    (tick && !restart && sel == 2'h0) |-> divTick)
    else $error("divide by one missed a tick");

endmodule : fdtm_prescaler

/* design/fdtm_top.sv */
// Purpose: Dual fan tachometer period monitor with threshold alarms
// Assumes: rtcClkIn is the 32.768kHz timebase, tach pins are asynchronous
// Notes:   Register port is the microcontroller byte bus
//
// Functional notes
// (R1) Two identical independent channels, each with prescaler, counter, preload, latch, detector.
// (R2) Per-channel timebase divide by 1, 2, 4 or 8; divide by 2 after reset.
// (R3) Counter advances once per prescaled timebase tick, measuring pulse period.
// (R4) Counter restarts on each rising tach edge and on preload register write.
// (R5) Restart on tach edge loads the programmed preload, not zero.
// (R6) Counter saturates at FF until next restart.
// (R7) Rising tach edge captures final count into read-only latch before restart.
// (R8) Threshold is AND of two top count bits: count at least 192.
// (R9) Enabled threshold assertion raises interrupt request to microcontroller.
// (R10) Software picks preload as 192 minus expected count at alarm speed.
// (R11) Software ignores latch until two tach pulses after a preload write.
// (R12) Prescaler register: channel one bits 1:0, two bits 3:2, reset 05.
// (R13) Channel two preload is read/write byte after channel one, resets zero.
// (R14) Each channel threshold drives a wake source flag in group seven.
// (R15) Tach inputs synchronised; edge capture and reload share one cycle.
// (R16) Tach edge with preload write reloads with newly written value.

`timescale 1ns/100ps

module fdtm_top (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    rtcClkIn,
  input  wire logic                    tachInputOne,
  input  wire logic                    tachInputTwo,
  input  wire fdtm_pkg::fdtm_bus_req_t busReq,
  input  wire logic [1:0]              irqEnable,
  output logic [7:0]                   rdData,
  output logic                         rdValid,
  output logic [1:0]                   thresholdLevel,
  output logic [1:0]                   wakeSourceSet,
  output logic                         irqRequest
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic [15:0] preload_addr(input int ch);
    return (ch == fdtm_pkg::CH_ONE) ? fdtm_pkg::ADDR_PRELOAD_ONE : fdtm_pkg::ADDR_PRELOAD_TWO;
  endfunction : preload_addr

  function automatic logic [15:0] latch_addr(input int ch);
    return (ch == fdtm_pkg::CH_ONE) ? fdtm_pkg::ADDR_LATCH_ONE : fdtm_pkg::ADDR_LATCH_TWO;
  endfunction : latch_addr

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0] tachPins;
  logic [1:0] tachRise;
  logic [1:0] preloadWrite;
  logic [1:0] restart;
  logic [1:0] divTick;
  logic       rtcTick;
  logic       prescaleWrite;
  logic [3:0] prescaler;
  logic [7:0] count      [fdtm_pkg::NUM_CH];
  logic [7:0] next_count [fdtm_pkg::NUM_CH];
  logic [7:0] periodLatch[fdtm_pkg::NUM_CH];
  logic [7:0] preload    [fdtm_pkg::NUM_CH];
  logic [1:0] next_threshold;
  logic [7:0] next_rdData;

  assign tachPins      = {tachInputTwo, tachInputOne};
  assign prescaleWrite = busReq.wr && (busReq.addr == fdtm_pkg::ADDR_PRESCALER);

  // ************************************************************
  // Timebase synchroniser
  // ************************************************************
  fdtm_sync_edge u_rtcSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (rtcClkIn),
    .rise    (rtcTick)
  );

  // ************************************************************
  // Per-channel front end
  // ************************************************************
  for (genvar g = 0; g < fdtm_pkg::NUM_CH; g++) begin : g_ch // see (R1)
    assign preloadWrite[g] = busReq.wr && (busReq.addr == preload_addr(g));
    assign restart[g]      = tachRise[g] | preloadWrite[g]; // see (R4)

    fdtm_sync_edge u_tachSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn (tachPins[g]),
      .rise    (tachRise[g])
    ); // see (R15)

    fdtm_prescaler u_prescaler (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (rtcTick),
      .restart (restart[g]),
      .sel     (prescaler[g*fdtm_pkg::PRESCALE_FIELD_W +: fdtm_pkg::PRESCALE_FIELD_W]),
      .divTick (divTick[g])
    ); // see (R2)
  end

  // ************************************************************
  // Pulse counters
  // ************************************************************
  always_comb begin
    for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
      if (preloadWrite[c]) begin
        next_count[c] = busReq.data; // see (R4) see (R16)
      end else if (tachRise[c]) begin
        next_count[c] = preload[c]; // see (R5)
      end else if (divTick[c] && count[c] != fdtm_pkg::COUNT_MAX) begin
        next_count[c] = 8'(count[c] + 8'h01); // see (R3)
      end else begin
        next_count[c] = count[c]; // see (R6)
      end
      next_threshold[c] = next_count[c][7] & next_count[c][6]; // see (R8)
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        count[c] <= fdtm_pkg::COUNT_RESET;
      end
    end else begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        count[c] <= next_count[c];
      end
    end
  end

  // ************************************************************
  // Read latches
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        periodLatch[c] <= fdtm_pkg::LATCH_RESET;
      end
    end else begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        if (tachRise[c]) begin
          periodLatch[c] <= count[c]; // see (R7) see (R15)
        end
      end
    end
  end

  // ************************************************************
  // Preload and prescaler registers
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        preload[c] <= fdtm_pkg::PRELOAD_RESET; // see (R13)
      end
    end else begin
      for (int c = 0; c < fdtm_pkg::NUM_CH; c++) begin
        if (preloadWrite[c]) begin
          preload[c] <= busReq.data; // see (R13)
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescaler <= fdtm_pkg::PRESCALE_RESET; // see (R2) see (R12)
    end else if (prescaleWrite) begin
      prescaler <= busReq.data[fdtm_pkg::PRESCALE_REG_W-1:0]; // see (R12)
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_comb begin
    next_rdData = fdtm_pkg::READ_IDLE;
    unique case (busReq.addr)
      latch_addr(fdtm_pkg::CH_ONE):   next_rdData = periodLatch[fdtm_pkg::CH_ONE];
      latch_addr(fdtm_pkg::CH_TWO):   next_rdData = periodLatch[fdtm_pkg::CH_TWO];
      preload_addr(fdtm_pkg::CH_ONE): next_rdData = preload[fdtm_pkg::CH_ONE];
      preload_addr(fdtm_pkg::CH_TWO): next_rdData = preload[fdtm_pkg::CH_TWO];
      fdtm_pkg::ADDR_PRESCALER:       next_rdData = {fdtm_pkg::RESERVED_READ, prescaler}; // see (R12)
      default:                        next_rdData = fdtm_pkg::READ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData  <= fdtm_pkg::READ_IDLE;
      rdValid <= 1'b0;
    end else begin
      rdValid <= busReq.rd;
      if (busReq.rd) begin
        rdData <= next_rdData;
      end
    end
  end

  // ************************************************************
  // Threshold, wake and interrupt outputs
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thresholdLevel <= 2'h0;
      wakeSourceSet  <= 2'h0;
      irqRequest     <= 1'b0;
    end else begin
      thresholdLevel <= next_threshold; // see (R8)
      wakeSourceSet  <= next_threshold & ~thresholdLevel; // see (R14)
      irqRequest     <= |(next_threshold & irqEnable); // see (R9)
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  saturate_hold_a: assert property ( // see (R6)
    (count[0] == fdtm_pkg::COUNT_MAX && !restart[0]) |=> count[0] == fdtm_pkg::COUNT_MAX)
    else $error("saturated count moved without restart");

  count_advance_a: assert property ( // see (R3)
    (divTick[1] && !restart[1] && count[1] != fdtm_pkg::COUNT_MAX) |=> count[1] == 8'($past(count[1]) + 8'h01))
    else $error("count did not advance on tick");

  edge_reload_a: assert property ( // see (R5)
    (tachRise[0] && !preloadWrite[0]) |=> count[0] == $past(preload[0]))
    else $error("edge did not load preload");

  write_wins_a: assert property ( // see (R16)
    (tachRise[1] && preloadWrite[1]) |=> (count[1] == $past(busReq.data)) && (preload[1] == count[1]))
    else $error("edge and write did not load new preload");

  latch_capture_a: assert property ( // see (R7)
    tachRise[0] |=> periodLatch[0] == $past(count[0]))
    else $error("latch missed final count");

  threshold_level_a: assert property ( // see (R8)
    thresholdLevel[1] == (count[1] >= fdtm_pkg::COUNT_THRESH))
    else $error("threshold disagrees with count");

  irq_gate_a: assert property ( // see (R9)
    (thresholdLevel[0] && irqEnable[0] && $stable(irqEnable)) |-> irqRequest)
    else $error("enabled threshold gave no interrupt");

  wake_pulse_a: assert property ( // see (R14)
    $rose(thresholdLevel[1]) |-> wakeSourceSet[1] ##1 !wakeSourceSet[1] || $rose(thresholdLevel[1]))
    else $error("wake source pulse wrong");

  prescale_write_a: assert property ( // see (R12)
    prescaleWrite |=> (prescaler == $past(busReq.data[3:0])) ##1 ($stable(prescaler) || $past(prescaleWrite)))
    else $error("prescaler write not held");

  read_latch_a: assert property ( // see (R7)
    (busReq.rd && busReq.addr == fdtm_pkg::ADDR_LATCH_TWO) |=> rdValid && rdData == $past(periodLatch[1]))
    else $error("latch read wrong");

  preload_restart_a: assert property ( // see (R4)
    preloadWrite[0] |=> (count[0] == $past(busReq.data)) && (preload[0] == count[0]))
    else $error("preload write did not restart count");

  saturate_two_a: assert property ( // see (R6)
    (count[1] == fdtm_pkg::COUNT_MAX && !restart[1]) |=> count[1] == fdtm_pkg::COUNT_MAX)
    else $error("saturated count two moved without restart");

  count_hold_a: assert property ( // see (R3)
    (!divTick[0] && !restart[0]) |=> $stable(count[0]))
    else $error("count moved without tick or restart");

  threshold_one_a: assert property ( // see (R8)
    thresholdLevel[0] == (count[0][7] && count[0][6]))
    else $error("threshold one disagrees with top count bits");

  latch_hold_a: assert property ( // see (R7)
    !tachRise[1] |=> $stable(periodLatch[1]))
    else $error("latch changed without tach edge");

  irq_quiet_a: assert property ( // see (R9)
    (irqEnable == 2'h0 && $stable(irqEnable)) |-> !irqRequest)
    else $error("interrupt raised while disabled");

  prescale_read_a: assert property ( // see (R12)
    (busReq.rd && busReq.addr == fdtm_pkg::ADDR_PRESCALER) |=>
      (rdData[7:4] == fdtm_pkg::RESERVED_READ) && (rdData[3:0] == $past(prescaler)))
    else $error("prescaler read wrong");

  preload_read_a: assert property ( // see (R13)
    (busReq.rd && busReq.addr == fdtm_pkg::ADDR_PRELOAD_TWO) |=> rdData == $past(preload[1]))
    else $error("preload two read wrong");

  saturate_c: cover property (count[0] == fdtm_pkg::COUNT_MAX ##1 tachRise[0]);
  alarm_c:    cover property ($rose(irqRequest));
  collide_c:  cover property (tachRise[1] && preloadWrite[1]);
  div8_c:     cover property (prescaler[1:0] == 2'h3 && divTick[0]);
  wake_c:     cover property (wakeSourceSet[0] ##1 !wakeSourceSet[0]);

endmodule : fdtm_top

/* tb/fdtm_fan_model.sv */
// Purpose: Fan tachometer output model, one instance per fan
// Assumes: Pulse width given in sys_clk cycles, wide enough to synchronise
// Notes:   Output rests low between pulses

`timescale 1ns/100ps

module fdtm_fan_model (
  input  wire logic sys_clk,
  output logic      tachOut
);
  initial tachOut = 1'b0;

  // ****************************************
  // Single speed pulse
  // ****************************************
  task automatic pulse(input int highCycles);
    @(posedge sys_clk);
    tachOut <= 1'b1;
    repeat (highCycles) @(posedge sys_clk);
    tachOut <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
endmodule : fdtm_fan_model

/* tb/dual_fan_tach_monitor_tb.sv */
// Purpose: Self-checking bench for the dual fan tachometer monitor
// Assumes: Timebase is stopped and stepped by the bench, so counts are exact
// Notes:   Timebase pulses are faster than the real oscillator to keep runs short

`timescale 1ns/100ps

module dual_fan_tach_monitor_tb;
  logic                    sys_clk;
  logic                    rst;
  logic                    rtcClkIn;
  logic                    tachOne;
  logic                    tachTwo;
  fdtm_pkg::fdtm_bus_req_t busReq;
  logic [1:0]              irqEnable;
  logic [7:0]              rdData;
  logic                    rdValid;
  logic [1:0]              thresholdLevel;
  logic [1:0]              wakeSourceSet;
  logic                    irqRequest;
  int                      fails;
  int                      num_checks;
  int                      wakeSeen [2];
  logic [7:0]              expLatch [2];

  fdtm_top i_fdtm_top (
    .sys_clk(sys_clk), .rst(rst), .rtcClkIn(rtcClkIn), .tachInputOne(tachOne),
    .tachInputTwo(tachTwo), .busReq(busReq), .irqEnable(irqEnable), .rdData(rdData),
    .rdValid(rdValid), .thresholdLevel(thresholdLevel), .wakeSourceSet(wakeSourceSet),
    .irqRequest(irqRequest)
  );
  fdtm_fan_model i_fdtm_fan_model_one (.sys_clk(sys_clk), .tachOut(tachOne));
  fdtm_fan_model i_fdtm_fan_model_two (.sys_clk(sys_clk), .tachOut(tachTwo));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (wakeSourceSet[0] === 1'b1) wakeSeen[0]++;
    if (wakeSourceSet[1] === 1'b1) wakeSeen[1]++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] expCount(input logic [7:0] pre, input int incs);
    int sum;
    sum = int'(pre) + incs;
    return (sum > 255) ? 8'hFF : sum[7:0];
  endfunction : expCount

  function automatic logic [15:0] latchAddr(input int c);
    return (c == 0) ? fdtm_pkg::ADDR_LATCH_ONE : fdtm_pkg::ADDR_LATCH_TWO;
  endfunction : latchAddr

  function automatic logic [15:0] preAddr(input int c);
    return (c == 0) ? fdtm_pkg::ADDR_PRELOAD_ONE : fdtm_pkg::ADDR_PRELOAD_TWO;
  endfunction : preAddr

  task automatic wrReg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    busReq <= '{1'b1, 1'b0, addr, data};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : wrReg

  task automatic rdChk(input string what, input logic [15:0] addr, input logic [7:0] exp);
    @(posedge sys_clk);
    busReq <= '{1'b0, 1'b1, addr, 8'h00};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    check("rdValid", {7'h00, rdValid}, 8'h01);
    check(what, rdData, exp);
  endtask : rdChk

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      rtcClkIn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rtcClkIn <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : ticks

  task automatic pulse(input int c);
    if (c == 0)
      i_fdtm_fan_model_one.pulse(4);
    else
      i_fdtm_fan_model_two.pulse(4);
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic measure(input int c, input logic [1:0] sel, input logic [7:0] pre, input int incs);
    logic [1:0] otherSel;
    otherSel = 2'($urandom % 4);
    wrReg(fdtm_pkg::ADDR_PRESCALER, (c == 0) ? {4'h0, otherSel, sel} : {4'h0, sel, otherSel});
    rdChk("prescaler", fdtm_pkg::ADDR_PRESCALER, (c == 0) ? {4'h0, otherSel, sel} : {4'h0, sel, otherSel});
    wrReg(preAddr(c), pre);
    pulse(c);
    expLatch[c] = pre;
    ticks(incs << sel);
    pulse(c);
    expLatch[c] = expCount(pre, incs);
    rdChk("latch", latchAddr(c), expLatch[c]);
    rdChk("other latch", latchAddr(1 - c), expLatch[1 - c]);
  endtask : measure

  task automatic threshold(input int c);
    int w;
    wrReg(fdtm_pkg::ADDR_PRESCALER, 8'h00);
    wrReg(preAddr(c), 8'hC0 - 8'h03);
    ticks(2);
    check("level low", {7'h00, thresholdLevel[c]}, 8'h00);
    w = wakeSeen[c];
    ticks(1);
    check("level high", {7'h00, thresholdLevel[c]}, 8'h01);
    check("wake pulses", 8'(wakeSeen[c] - w), 8'h01);
    check("irq masked", {7'h00, irqRequest}, 8'h00);
    @(posedge sys_clk);
    irqEnable[c] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq raised", {7'h00, irqRequest}, 8'h01);
    wrReg(preAddr(c), 8'h10);
    repeat (2) @(posedge sys_clk);
    #1;
    check("level cleared", {7'h00, thresholdLevel[c]}, 8'h00);
    check("irq cleared", {7'h00, irqRequest}, 8'h00);
    @(posedge sys_clk);
    irqEnable <= 2'b00;
    ticks(2);
    pulse(c);
    expLatch[c] = 8'h12;
    rdChk("latch after write", latchAddr(c), expLatch[c]);
  endtask : threshold

  task automatic sameCycle(input int c);
    wrReg(preAddr(c), 8'h20);
    pulse(c);
    ticks(3);
    fork
      pulse(c);
      begin
        repeat (3) @(posedge sys_clk);
        wrReg(preAddr(c), 8'h55);
      end
    join
    rdChk("latch old count", latchAddr(c), 8'h23);
    pulse(c);
    expLatch[c] = 8'h55;
    rdChk("latch new preload", latchAddr(c), expLatch[c]);
  endtask : sameCycle

  initial begin
    rst = 1'b1;
    rtcClkIn = 1'b0;
    busReq = '0;
    irqEnable = 2'b00;
    fails = 0;
    num_checks = 0;
    wakeSeen = '{0, 0};
    expLatch = '{8'h00, 8'h00};
    void'($urandom(99));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk("latch one reset", fdtm_pkg::ADDR_LATCH_ONE, 8'h00);
    rdChk("latch two reset", fdtm_pkg::ADDR_LATCH_TWO, 8'h00);
    rdChk("preload one reset", fdtm_pkg::ADDR_PRELOAD_ONE, 8'h00);
    rdChk("preload two reset", fdtm_pkg::ADDR_PRELOAD_TWO, 8'h00);
    rdChk("prescaler reset", fdtm_pkg::ADDR_PRESCALER, 8'h05);
    rdChk("unmapped", 16'h7FA0, 8'h00);
    wrReg(fdtm_pkg::ADDR_LATCH_ONE, 8'hAA);
    rdChk("latch read only", fdtm_pkg::ADDR_LATCH_ONE, 8'h00);
    wrReg(fdtm_pkg::ADDR_PRESCALER, 8'hFF);
    rdChk("prescaler reserved", fdtm_pkg::ADDR_PRESCALER, 8'h0F);
    wrReg(fdtm_pkg::ADDR_PRELOAD_TWO, 8'hA5);
    rdChk("preload two rw", fdtm_pkg::ADDR_PRELOAD_TWO, 8'hA5);
    for (int c = 0; c < 2; c++) begin
      threshold(c);
      sameCycle(c);
      measure(c, 2'h0, 8'hFE, 5);
    end
    for (int i = 0; i < 12; i++) begin
      measure(i % 2, 2'((i / 2) % 4), 8'($urandom % 256), int'($urandom % 8));
    end
    conclude();
  end

  initial begin
    #3000000;
    fails++;
    conclude();
  end
endmodule : dual_fan_tach_monitor_tb
